//--- include/slow_idle_pkg.sv
// Constants and carriers for the slow idle clock and boot mode block.
// Assumes one 100 MHz clock, active-low asynchronous reset, AHB-Lite registers.
package slow_idle_pkg;

  localparam logic [7:0] div_16 = 8'h10;
  localparam logic [7:0] div_32 = 8'h20;
  localparam logic [7:0] div_64 = 8'h40;
  localparam logic [7:0] div_128 = 8'h80;

  localparam logic [15:0] start_ram = 16'h0000;
  localparam logic [15:0] start_ext = 16'h0000;
  localparam logic [15:0] start_rom = 16'h0800;

  // Register byte addresses
  localparam logic [3:0] reg_ctrl = 4'h0;
  localparam logic [3:0] reg_status = 4'h4;
  localparam logic [3:0] reg_boot = 4'h8;

  // Control register fields
  localparam int ctrl_idle_bit = 0;
  localparam int ctrl_div_lsb = 8;
  localparam int ctrl_rom_bit = 16;

  localparam logic [7:0] ctrl_div_reset = 8'h00;

  // Status and boot register fields
  localparam int stat_state_lsb = 0;
  localparam int stat_wake_bit = 2;
  localparam int stat_div_lsb = 8;
  localparam int boot_mode_lsb = 0;
  localparam int boot_rom_bit = 2;
  localparam int boot_start_lsb = 16;

  typedef enum logic [1:0] {
    boot_eprom,
    boot_host,
    boot_none,
    boot_rom
  } boot_e;

  typedef struct packed {
    boot_e mode;
    logic rom_enable;
    logic [15:0] start_addr;
  } boot_s;

  typedef struct packed {
    logic proc_en;
    logic serial_en;
    logic timer_en;
  } clk_en_s;

endpackage

//--- rtl/boot_strap_latch.sv
// Start-up mode latch: samples the two straps while hold_reset is high, keeps the value taken on the first edge after it falls.
// Assumes strap pins are static during reset and were synchronised outside.
`timescale 1ns/100ps
module boot_strap_latch (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic hold_reset,
  input wire logic memory_map_strap,
  input wire logic boot_source_strap,
  output slow_idle_pkg::boot_s boot
);

  slow_idle_pkg::boot_s next_boot;
  logic captured;
  logic next_captured;

  always_comb begin
    next_boot = boot;
    next_captured = captured;
    if (hold_reset) begin
      next_captured = 1'b0;
    end
    if (!captured) begin
      next_captured = !hold_reset;
      case ({memory_map_strap, boot_source_strap})
        2'b00: begin
          next_boot.mode = slow_idle_pkg::boot_eprom;
          next_boot.rom_enable = 1'b0;
          next_boot.start_addr = slow_idle_pkg::start_ram;
        end
        2'b01: begin
          next_boot.mode = slow_idle_pkg::boot_host;
          next_boot.rom_enable = 1'b0;
          next_boot.start_addr = slow_idle_pkg::start_ram;
        end
        2'b10: begin
          next_boot.mode = slow_idle_pkg::boot_none;
          next_boot.rom_enable = 1'b0;
          next_boot.start_addr = slow_idle_pkg::start_ext;
        end
        default: begin
          next_boot.mode = slow_idle_pkg::boot_rom;
          next_boot.rom_enable = 1'b1;
          next_boot.start_addr = slow_idle_pkg::start_rom;
        end
      endcase
    end
  end

  // Sampling stops one edge after hold_reset falls, so the mode holds till next reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      boot <= '0;
      captured <= 1'b0;
    end else if (ce) begin
      boot <= next_boot;
      captured <= next_captured;
    end
  end

endmodule

//--- rtl/slow_idle_clock.sv
// Slow idle clock control with start-up mode selection.
// Assumes an AHB-Lite master on clk; straps and interrupt request are pins.
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module slow_idle_clock #(
  parameter int div_width = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic idle_req,
  input wire logic [div_width-1:0] idle_div,
  input wire logic irq_pin,
  input wire logic memory_map_strap,
  input wire logic boot_source_strap,
  output logic clock_output_pin,
  output slow_idle_pkg::clk_en_s clk_en,
  output logic idle_active,
  output logic wake,
  output slow_idle_pkg::boot_s boot
);

  typedef enum logic [1:0] {
    run,
    idle_plain,
    idle_slow
  } idle_state_e;

  // Pin synchronisers
  logic [1:0] irq_sync;
  logic [1:0] memory_map_strap_sync;
  logic [1:0] bsrc_sync;
  logic [1:0] next_irq_sync;
  logic [1:0] next_memory_map_strap_sync;
  logic [1:0] next_bsrc_sync;
  logic irq_s;

  always_comb begin
    next_irq_sync = {irq_sync[0], irq_pin};
    next_memory_map_strap_sync = {memory_map_strap_sync[0], memory_map_strap};
    next_bsrc_sync = {bsrc_sync[0], boot_source_strap};
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_sync <= 2'b00;
      memory_map_strap_sync <= 2'b00;
      bsrc_sync <= 2'b00;
    end else if (ce) begin
      irq_sync <= next_irq_sync;
      memory_map_strap_sync <= next_memory_map_strap_sync;
      bsrc_sync <= next_bsrc_sync;
    end
  end

  assign irq_s = irq_sync[1];

  // Reset hold: the strap latch samples on the first three edges after reset release
  logic [1:0] rst_hold;
  logic [1:0] next_rst_hold;

  always_comb begin
    next_rst_hold = {rst_hold[0], 1'b1};
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_hold <= 2'b00;
    end else if (ce) begin
      rst_hold <= next_rst_hold;
    end
  end

  slow_idle_pkg::boot_s boot_raw;

  boot_strap_latch u_latch (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .hold_reset(!rst_hold[1]),
    .memory_map_strap(memory_map_strap_sync[1]),
    .boot_source_strap(bsrc_sync[1]),
    .boot(boot_raw)
  );

  // Register bus
  logic [31:0] next_hrdata;
  logic wr_pend;
  logic next_wr_pend;
  logic [3:0] wr_addr;
  logic [3:0] next_wr_addr;
  logic [div_width-1:0] sw_div;
  logic [div_width-1:0] next_sw_div;
  logic sw_idle;
  logic next_sw_idle;
  logic rom_override;
  logic next_rom_override;
  logic take;

  // Idle state
  idle_state_e state;
  idle_state_e next_state;
  logic [div_width-1:0] cnt;
  logic [div_width-1:0] next_cnt;
  logic [div_width-1:0] div_sel;
  logic [div_width-1:0] next_div_sel;
  logic wake_pend;
  logic next_wake_pend;
  logic next_wake;
  logic next_clk_out;
  slow_idle_pkg::clk_en_s next_clk_en;
  logic next_idle_active;

  function automatic logic div_ok(input logic [div_width-1:0] d);
    div_ok = (d == div_width'(slow_idle_pkg::div_16)) ||
             (d == div_width'(slow_idle_pkg::div_32)) ||
             (d == div_width'(slow_idle_pkg::div_64)) ||
             (d == div_width'(slow_idle_pkg::div_128));
  endfunction

  assign take = hsel && hready && htrans[1];

  always_comb begin
    next_wr_pend = take && hwrite;
    next_wr_addr = take ? haddr[3:0] : wr_addr;
    next_sw_div = sw_div;
    next_sw_idle = 1'b0;
    next_rom_override = rom_override;
    next_hrdata = 32'h0000_0000;
    if (wr_pend && wr_addr == slow_idle_pkg::reg_ctrl) begin
      next_sw_div = hwdata[slow_idle_pkg::ctrl_div_lsb +: div_width];
      next_sw_idle = hwdata[slow_idle_pkg::ctrl_idle_bit];
      next_rom_override = hwdata[slow_idle_pkg::ctrl_rom_bit];
    end
    if (take && !hwrite) begin
      case (haddr[3:0])
        slow_idle_pkg::reg_ctrl: begin
          next_hrdata[slow_idle_pkg::ctrl_div_lsb +: div_width] = sw_div;
          next_hrdata[slow_idle_pkg::ctrl_rom_bit] = rom_override;
        end
        slow_idle_pkg::reg_status: begin
          next_hrdata[slow_idle_pkg::stat_state_lsb +: 2] = state;
          next_hrdata[slow_idle_pkg::stat_wake_bit] = wake_pend;
          next_hrdata[slow_idle_pkg::stat_div_lsb +: div_width] = div_sel;
        end
        slow_idle_pkg::reg_boot: begin
          next_hrdata[slow_idle_pkg::boot_mode_lsb +: 2] = boot.mode;
          next_hrdata[slow_idle_pkg::boot_rom_bit] = boot.rom_enable;
          next_hrdata[slow_idle_pkg::boot_start_lsb +: 16] = boot.start_addr;
        end
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
      wr_pend <= 1'b0;
      wr_addr <= 4'h0;
      sw_div <= div_width'(slow_idle_pkg::ctrl_div_reset);
      sw_idle <= 1'b0;
      rom_override <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      hrdata <= next_hrdata;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      sw_div <= next_sw_div;
      sw_idle <= next_sw_idle;
      rom_override <= next_rom_override;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Start-up mode output; software may only add ROM enable after the hold window
  slow_idle_pkg::boot_s next_boot;

  always_comb begin
    next_boot = boot_raw;
    if (rst_hold[1]) begin
      next_boot.rom_enable = boot_raw.rom_enable | rom_override;
    end else begin
      next_boot.rom_enable = boot_raw.rom_enable;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      boot <= '0;
    end else if (ce) begin
      boot <= next_boot;
    end
  end

  // Idle and divided clock engine
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_div_sel = div_sel;
    next_wake_pend = wake_pend;
    next_wake = 1'b0;
    next_clk_out = !clock_output_pin;
    case (state)
      run: begin
        if (idle_req || sw_idle) begin
          next_div_sel = idle_req ? idle_div : sw_div;
          if (div_ok(next_div_sel)) begin
            next_state = idle_slow;
            next_cnt = next_div_sel - div_width'(1);
          end else begin
            next_state = idle_plain;
            next_div_sel = div_width'(1);
          end
          next_wake_pend = 1'b0;
        end
      end
      idle_plain: begin
        if (irq_s) begin
          next_state = run;
          next_wake = 1'b1;
        end
      end
      idle_slow: begin
        next_cnt = (cnt == '0) ? div_sel - div_width'(1) : cnt - div_width'(1);
        if (irq_s) begin
          next_wake_pend = 1'b1;
        end
        // Leave only at a slow-tick boundary, never mid-pulse
        if ((irq_s || wake_pend) && cnt == '0) begin
          next_state = run;
          next_wake = 1'b1;
          next_wake_pend = 1'b0;
        end
      end
      default: next_state = run;
    endcase
    // Processor slows, the clock output pin does not; serial and timer clocks share its one enable
    next_clk_en.proc_en = (next_state != idle_slow) || (next_cnt == '0);
    next_clk_en.serial_en = next_clk_en.proc_en;
    next_clk_en.timer_en = next_clk_en.proc_en;
    next_idle_active = (next_state != run);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= run;
      cnt <= '0;
      div_sel <= div_width'(1);
      wake_pend <= 1'b0;
      wake <= 1'b0;
      clock_output_pin <= 1'b0;
      clk_en <= '1;
      idle_active <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      cnt <= next_cnt;
      div_sel <= next_div_sel;
      wake_pend <= next_wake_pend;
      wake <= next_wake;
      clock_output_pin <= next_clk_out;
      clk_en <= next_clk_en;
      idle_active <= next_idle_active;
    end
  end

endmodule

//--- test/slow_idle_monitor.sv
// Checker for the slow idle clock block, watching the top module's ports only.
// Assumes ce is held high by the bench; bound to every slow_idle_clock instance.
`timescale 1ns/100ps
module slow_idle_monitor (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic idle_req,
  input wire logic irq_pin,
  input wire logic clock_output_pin,
  input wire slow_idle_pkg::clk_en_s clk_en,
  input wire logic idle_active,
  input wire logic wake,
  input wire slow_idle_pkg::boot_s boot
);
  logic [2:0] settle;
  logic [2:0] next_settle;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // Edges since reset release, saturating
  always_comb begin
    next_settle = settle;
    if (ce && settle != 3'h7) begin
      next_settle = settle + 3'h1;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      settle <= 3'h0;
    end else begin
      settle <= next_settle;
    end
  end

  chk_pin_full_rate: assert property (ce |=>
    clock_output_pin != $past(clock_output_pin))
    else $error("clock output pin missed a toggle");
  chk_serial_timer_track: assert property (clk_en.serial_en == clk_en.proc_en
    && clk_en.timer_en == clk_en.proc_en) else $error("serial or timer enable off track");
  chk_run_full_rate: assert property (!idle_active |-> clk_en.proc_en)
    else $error("processor enable low outside idle");
  chk_idle_entry: assert property (idle_req && !idle_active && ce |=> idle_active)
    else $error("idle request not taken");
  chk_wake_pulse: assert property (wake |=> !wake)
    else $error("wake longer than one cycle");
  chk_wake_exit: assert property (wake |-> !idle_active && $past(idle_active))
    else $error("wake without leaving idle");
  chk_irq_bound: assert property ($rose(irq_pin) && idle_active |-> ##[1:135] wake)
    else $error("interrupt wake too slow");
  chk_rom_start: assert property (boot.mode == slow_idle_pkg::boot_rom
    |-> boot.rom_enable && boot.start_addr == slow_idle_pkg::start_rom)
    else $error("standalone start wrong");
  chk_ram_start: assert property (boot.mode != slow_idle_pkg::boot_rom
    |-> boot.start_addr == 16'h0000) else $error("start address not zero");
  chk_boot_frozen: assert property (settle == 3'h7 |-> $stable(boot))
    else $error("start-up mode changed after reset");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
endmodule

bind slow_idle_clock slow_idle_monitor slow_idle_monitor_i (.clk(clk), .nrst(nrst), .ce(ce),
  .hreadyout(hreadyout), .hresp(hresp), .idle_req(idle_req), .irq_pin(irq_pin),
  .clock_output_pin(clock_output_pin), .clk_en(clk_en), .idle_active(idle_active),
  .wake(wake), .boot(boot));

//--- test/idle_sequencer_model.sv
// Program sequencer model: issues idle requests and interrupt requests.
// Assumes the bench calls its tasks; signals change just after a rising edge.
`timescale 1ns/100ps
module idle_sequencer_model (
  input wire logic clk,
  input wire logic wake,
  output logic idle_req,
  output logic [7:0] idle_div,
  output logic irq_pin
);
  initial begin
    idle_req = 1'b0;
    idle_div = 8'h00;
    irq_pin = 1'b0;
  end

  task automatic enter_idle(input logic [7:0] d);
    @(posedge clk);
    idle_req <= 1'b1;
    idle_div <= d;
    @(posedge clk);
    idle_req <= 1'b0;
    idle_div <= ~d;
  endtask

  // Holds the request until wake, then spaces out the next one
  task automatic interrupt(output int lat);
    @(posedge clk);
    irq_pin <= 1'b1;
    lat = 0;
    do begin
      @(posedge clk);
      lat++;
    end while (wake !== 1'b1 && lat < 400);
    irq_pin <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule

//--- test/slow_idle_clock_tb.sv
// Testbench for slow_idle_clock: strap decoding, idle division, wake, registers.
// Assumes a zero-wait AHB-Lite slave and the sequencer model beside it.
`timescale 1ns/100ps
module slow_idle_clock_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic memory_map_strap = 1'b0;
  logic boot_source_strap = 1'b0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, clock_output_pin, idle_active, wake, idle_req, irq_pin;
  logic [7:0] idle_div;
  logic [15:0] start;
  slow_idle_pkg::clk_en_s clk_en;
  slow_idle_pkg::boot_s boot;
  logic [7:0] divs [5] = '{slow_idle_pkg::div_16, slow_idle_pkg::div_32,
    slow_idle_pkg::div_64, slow_idle_pkg::div_128, 8'h05};
  int n_fail = 0, total_checks = 0, cycles = 0, n, lat, gap, expgap;

  slow_idle_clock slow_idle_clock_i (.clk(clk), .nrst(nrst), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .idle_req(idle_req), .idle_div(idle_div), .irq_pin(irq_pin),
    .memory_map_strap(memory_map_strap), .boot_source_strap(boot_source_strap),
    .clock_output_pin(clock_output_pin), .clk_en(clk_en), .idle_active(idle_active),
    .wake(wake), .boot(boot));
  idle_sequencer_model idle_sequencer_model_i (.clk(clk), .wake(wake), .idle_req(idle_req),
    .idle_div(idle_div), .irq_pin(irq_pin));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  initial begin
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      nrst <= 1'b0;
      memory_map_strap <= i[1];
      boot_source_strap <= i[0];
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (8) @(posedge clk);
      memory_map_strap <= ~i[1];
      boot_source_strap <= ~i[0];
      start = (i == 3) ? slow_idle_pkg::start_rom : 16'h0000;
      chk({boot.mode, boot.rom_enable, boot.start_addr}, {i[1:0], i == 3, start});
      repeat (6) @(posedge clk);
      bus(1'b0, {28'h0, slow_idle_pkg::reg_boot}, 32'h0);
      chk(rd, {start, 13'h0, i == 3, i[1:0]});
    end
    foreach (divs[k]) begin
      expgap = (k < 4) ? divs[k] : 1;
      idle_sequencer_model_i.enter_idle(divs[k]);
      n = 0;
      do @(posedge clk); while (!(idle_active === 1'b1 && clk_en.proc_en === 1'b1) && ++n < 300);
      gap = 0;
      do begin
        @(posedge clk);
        gap++;
      end while (clk_en.proc_en !== 1'b1 && gap < 300);
      chk(gap, expgap);
      idle_sequencer_model_i.interrupt(lat);
      chk(lat <= expgap + 4, 1);
    end
    bus(1'b1, {28'h0, slow_idle_pkg::reg_ctrl}, {15'h0, 1'b1, slow_idle_pkg::div_32, 8'h01});
    bus(1'b0, {28'h0, slow_idle_pkg::reg_status}, 32'h0);
    chk({idle_active, rd[15:8]}, {1'b1, slow_idle_pkg::div_32});
    bus(1'b0, {28'h0, slow_idle_pkg::reg_ctrl}, 32'h0);
    chk(rd, {15'h0, 1'b1, slow_idle_pkg::div_32, 8'h00});
    idle_sequencer_model_i.interrupt(lat);
    chk(lat <= 36, 1);
    bus(1'b0, 32'h0000000C, 32'h0);
    chk(rd, 32'h0);
    summarize();
  end
endmodule
